// >>> src/pdma_top.sv
// Peripheral DMA unit: eleven channels, fixed-priority arbiter, bus master
//
// Behaviour
// - Eleven channels: a receive and transmit pair per serial port and SPI, one ADC receive.
// - A memory-to-peripheral transfer holds the memory bus until mem_ready, one cycle at the least.
// - A peripheral-to-memory transfer captures into the FIFO, then holds the bus for its write until mem_ready.
// - Grants go by fixed priority, all receive channels above all transmit channels.
// - Each channel keeps a next pointer and count and chains into them when a buffer ends.
`timescale 1ns/100ps
`include "pdma_params.svh"
module pdma_top #(
  parameter int NUM_RX = `PDMA_NUM_RX,
  parameter int NUM_TX = `PDMA_NUM_TX,
  parameter int DW     = `PDMA_DATA_W,
  parameter int AW     = `PDMA_ADDR_W,
  parameter int CW     = `PDMA_CNT_W,
  parameter int FDEPTH = `PDMA_FIFO_DEPTH
) (
  input  wire logic                       core_clk,
  input  wire logic                       arst_n,
  // Peripheral side
  input  wire logic [NUM_RX-1:0]          rx_req,
  input  wire logic [NUM_RX-1:0][DW-1:0]  rx_data,
  output logic      [NUM_RX-1:0]          rx_ack,
  input  wire logic [NUM_TX-1:0]          tx_req,
  output logic      [DW-1:0]              tx_data,
  output logic      [NUM_TX-1:0]          tx_ack,
  // Channel setup
  input  wire logic                       cfg_cur_we,
  input  wire logic                       cfg_next_we,
  input  wire pdma_pkg::pdma_chan_t       cfg_chan,
  input  wire logic [AW-1:0]              cfg_ptr,
  input  wire logic [CW-1:0]              cfg_cnt,
  output logic      [NUM_RX+NUM_TX-1:0]   buf_done,
  // Memory bus master
  output logic                            mem_valid,
  output logic                            mem_write,
  output logic      [AW-1:0]              mem_addr,
  output logic      [DW-1:0]              mem_wdata,
  input  wire logic [DW-1:0]              mem_rdata,
  input  wire logic                       mem_ready
);
  import pdma_pkg::*;

  localparam int NCH = NUM_RX + NUM_TX;
  localparam int FW  = AW + DW;

  // Lowest set bit; low indices are the higher priority channels
  function automatic logic [`PDMA_CH_W-1:0] first_set(input logic [NCH-1:0] v);
    logic [`PDMA_CH_W-1:0] idx;
    idx = '0;
    for (int k = NCH - 1; k >= 0; k--)
    begin
      if (v[k])
        idx = k[`PDMA_CH_W-1:0];
    end
    return idx;
  endfunction

  logic [AW-1:0] cur_ptr  [NCH];
  logic [CW-1:0] cur_cnt  [NCH];
  logic [AW-1:0] nxt_ptr  [NCH];
  logic [CW-1:0] nxt_cnt  [NCH];
  logic [NCH-1:0]           cnt_live;
  pdma_state_t              state;
  pdma_state_t              next_state;
  logic [`PDMA_CH_W-1:0]    tx_chan;

  pdma_fifo_if #(.WIDTH(FW)) rxq ();

  pdma_fifo #(
    .WIDTH (FW),
    .DEPTH (FDEPTH)
  ) u_rx_fifo (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .q        (rxq)
  );

  // Channel eligibility and arbitration
  wire [NUM_RX-1:0]       rx_elig  = rx_req & cnt_live[NUM_RX-1:0];
  wire [NUM_TX-1:0]       tx_elig  = tx_req & cnt_live[NCH-1:NUM_RX];
  wire [NUM_RX-1:0]       rx_cand  = rx_elig & {NUM_RX{rxq.in_ready}};
  wire                    is_idle  = (state == PDMA_S_IDLE);
  wire                    rx_go    = is_idle && (|rx_cand);
  wire                    drain_go = is_idle && !(|rx_cand) && rxq.out_valid;
  wire                    tx_go    = is_idle && !(|rx_cand) && !rxq.out_valid
                                     && (|tx_elig);
  wire [`PDMA_CH_W-1:0]   gnt_idx  = first_set({tx_elig, rx_cand});
  wire                    gnt_fire = rx_go || tx_go;
  wire [AW-1:0]           gnt_addr = cur_ptr[gnt_idx];
  wire [DW-1:0]           gnt_rxd  = rx_data[gnt_idx[`PDMA_TX_SLOT_W-1:0]];
  wire [`PDMA_CH_W-1:0]   tx_base  = `PDMA_CH_W'(NUM_RX);
  wire [`PDMA_TX_SLOT_W-1:0] tx_slot = `PDMA_TX_SLOT_W'(tx_chan - tx_base);
  wire                    bus_done = mem_valid && mem_ready;

  // Capture cycle of a receive transfer; the write follows from the FIFO
  assign rxq.in_valid  = rx_go;
  assign rxq.in_data   = {gnt_addr, gnt_rxd};
  assign rxq.out_ready = (state == PDMA_S_WR) && mem_ready;

  // Per-channel pointer, count and chained buffer
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_chan
      wire hit     = gnt_fire && (gnt_idx == gi);
      wire last    = (cur_cnt[gi] == CW'(1));
      wire chain   = hit && last && (nxt_cnt[gi] != '0);
      wire sel_cfg = (cfg_chan == gi);

      assign cnt_live[gi] = (cur_cnt[gi] != '0);

      // Setup writes win over the transfer update of the same cycle
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          cur_ptr[gi] <= `PDMA_ADDR_RESET;
          cur_cnt[gi] <= `PDMA_CNT_RESET;
        end
        else if (cfg_cur_we && sel_cfg)
        begin
          cur_ptr[gi] <= cfg_ptr;
          cur_cnt[gi] <= cfg_cnt;
        end
        else if (chain)
        begin
          cur_ptr[gi] <= nxt_ptr[gi];
          cur_cnt[gi] <= nxt_cnt[gi];
        end
        else if (hit)
        begin
          cur_ptr[gi] <= cur_ptr[gi] + `PDMA_ADDR_STEP;
          cur_cnt[gi] <= cur_cnt[gi] - CW'(1);
        end
      end

      // Next buffer is consumed once it has been chained in
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          nxt_ptr[gi] <= `PDMA_ADDR_RESET;
          nxt_cnt[gi] <= `PDMA_CNT_RESET;
        end
        else if (cfg_next_we && sel_cfg)
        begin
          nxt_ptr[gi] <= cfg_ptr;
          nxt_cnt[gi] <= cfg_cnt;
        end
        else if (chain)
          nxt_cnt[gi] <= `PDMA_CNT_RESET;
      end

      // Buffer end pulse, also when the next buffer is empty
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          buf_done[gi] <= 1'b0;
        else
          buf_done[gi] <= hit && last;
      end
    end
  endgenerate

  // Engine sequencing; the ACK state keeps a held request from a double grant
  always_comb
  begin
    next_state = state;
    case (state)
      PDMA_S_IDLE:
      begin
        if (rx_go)
          next_state = PDMA_S_ACK;
        else if (drain_go)
          next_state = PDMA_S_WR;
        else if (tx_go)
          next_state = PDMA_S_RD;
      end
      PDMA_S_WR:  next_state = mem_ready ? PDMA_S_IDLE : PDMA_S_WR;
      PDMA_S_RD:  next_state = mem_ready ? PDMA_S_ACK : PDMA_S_RD;
      PDMA_S_ACK: next_state = PDMA_S_IDLE;
      default:    next_state = PDMA_S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= PDMA_S_IDLE;
    else
      state <= next_state;
  end

  // Bus master: one read cycle per transmit word, one write per received word
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_valid <= 1'b0;
      mem_write <= 1'b0;
      mem_addr  <= `PDMA_ADDR_RESET;
      mem_wdata <= '0;
      tx_chan   <= '0;
    end
    else if (drain_go)
    begin
      mem_valid <= 1'b1;
      mem_write <= 1'b1;
      mem_addr  <= rxq.out_data[FW-1:DW];
      mem_wdata <= rxq.out_data[DW-1:0];
    end
    else if (tx_go)
    begin
      mem_valid <= 1'b1;
      mem_write <= 1'b0;
      mem_addr  <= gnt_addr;
      tx_chan   <= gnt_idx;
    end
    else if (bus_done)
    begin
      mem_valid <= 1'b0;
      mem_write <= 1'b0;
    end
  end

  // Acknowledges to the peripherals, one cycle each
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_ack  <= '0;
      tx_ack  <= '0;
      tx_data <= '0;
    end
    else
    begin
      rx_ack <= rx_go ? (NUM_RX'(1) << gnt_idx[`PDMA_TX_SLOT_W-1:0]) : '0;
      if ((state == PDMA_S_RD) && mem_ready)
      begin
        tx_ack  <= NUM_TX'(1) << tx_slot;
        tx_data <= mem_rdata;
      end
      else
        tx_ack <= '0;
    end
  end
endmodule

// >>> include/pdma_params.svh
// Constants for the peripheral DMA channel arbiter
`ifndef PDMA_PARAMS_SVH
`define PDMA_PARAMS_SVH

`define PDMA_NUM_CH         11
`define PDMA_NUM_RX         6
`define PDMA_NUM_TX         5
`define PDMA_CH_W           4
`define PDMA_TX_SLOT_W      3
`define PDMA_DATA_W         32
`define PDMA_ADDR_W         32
`define PDMA_CNT_W          16
`define PDMA_ADDR_STEP      32'h0000_0004
`define PDMA_FIFO_DEPTH     16
`define PDMA_TX_BUS_CYCLES  1
`define PDMA_RX_BUS_CYCLES  2
`define PDMA_CNT_RESET      16'h0000
`define PDMA_ADDR_RESET     32'h0000_0000

`endif

// >>> include/pdma_pkg.sv
// Types for the peripheral DMA channel arbiter
package pdma_pkg;

  // Channel numbers, lower number wins arbitration
  typedef enum logic [3:0] {
    PDMA_RX_DEBUG  = 4'h0,
    PDMA_RX_PORT0  = 4'h1,
    PDMA_RX_PORT1  = 4'h2,
    PDMA_RX_SYNC   = 4'h3,
    PDMA_RX_ADC    = 4'h4,
    PDMA_RX_SPI    = 4'h5,
    PDMA_TX_DEBUG  = 4'h6,
    PDMA_TX_PORT0  = 4'h7,
    PDMA_TX_PORT1  = 4'h8,
    PDMA_TX_SYNC   = 4'h9,
    PDMA_TX_SPI    = 4'ha
  } pdma_chan_t;

  // Engine states, one-hot
  typedef enum logic [3:0] {
    PDMA_S_IDLE = 4'h1,
    PDMA_S_WR   = 4'h2,
    PDMA_S_RD   = 4'h4,
    PDMA_S_ACK  = 4'h8
  } pdma_state_t;

endpackage

// >>> include/pdma_fifo_if.sv
// Valid/ready carrier between the engine and its receive FIFO
`timescale 1ns/100ps
interface pdma_fifo_if #(parameter int WIDTH = 64);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// >>> src/pdma_fifo.sv
// Synchronous FIFO for captured receive words
`timescale 1ns/100ps
module pdma_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  pdma_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  // Extra pointer bit tells full from empty
  wire full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push  = q.in_valid && !full;
  wire pop   = q.out_ready && !empty;

  assign q.in_ready  = !full;
  assign q.out_valid = !empty;
  assign q.out_data  = store[rd_ptr[AW-1:0]];

  // Storage has no reset, only the pointers matter
  always_ff @(posedge core_clk)
  begin
    if (push)
      store[wr_ptr[AW-1:0]] <= q.in_data;
  end

  // Pointer update
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// >>> verif/pdma_top_assertions.sv
// Concurrent checks on the ports of the peripheral DMA unit
`timescale 1ns/100ps
module pdma_top_assertions #(
  parameter int NUM_RX = 6,
  parameter int NUM_TX = 5,
  parameter int DW     = 32,
  parameter int AW     = 32
) (
  input wire logic              core_clk,
  input wire logic              arst_n,
  input wire logic [NUM_RX-1:0] rx_req,
  input wire logic [NUM_RX-1:0] rx_ack,
  input wire logic [NUM_TX-1:0] tx_ack,
  input wire logic [DW-1:0]     tx_data,
  input wire logic              mem_valid,
  input wire logic              mem_write,
  input wire logic [AW-1:0]     mem_addr,
  input wire logic [DW-1:0]     mem_rdata,
  input wire logic              mem_ready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Bus steps of one transfer
  sequence rd_done;
    mem_valid && !mem_write && mem_ready;
  endsequence
  sequence wr_issue;
    mem_valid && mem_write;
  endsequence
  a_one_grant: assert property ($onehot0({rx_ack, tx_ack}))
    else $error("two channels acknowledged together");
  a_ack_spacing: assert property (|{rx_ack, tx_ack} |=> {rx_ack, tx_ack} == '0)
    else $error("acknowledges in adjacent cycles");
  a_ack_needs_req: assert property (|rx_ack |-> (rx_ack & ~$past(rx_req)) == '0)
    else $error("receive ack without request");
  a_bus_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr))
    else $error("bus request changed before ready");
  a_bus_release: assert property (mem_valid && mem_ready |=> !mem_valid)
    else $error("bus request not dropped after ready");
  a_tx_ack_read: assert property (rd_done |=> |tx_ack && tx_data == $past(mem_rdata))
    else $error("read word not handed to transmit channel");
  a_tx_ack_cause: assert property (|tx_ack |-> $past(mem_valid) && !$past(mem_write))
    else $error("transmit ack without a memory read");
  a_rx_drain: assert property (|rx_ack |-> ##[1:30] wr_issue)
    else $error("captured word never written to memory");
endmodule
bind pdma_top pdma_top_assertions #(.NUM_RX(NUM_RX), .NUM_TX(NUM_TX), .DW(DW), .AW(AW)) u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .rx_req(rx_req), .rx_ack(rx_ack), .tx_ack(tx_ack),
  .tx_data(tx_data), .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
  .mem_rdata(mem_rdata), .mem_ready(mem_ready));

// >>> verif/pdma_mem_model.sv
// Behavioural system memory answering the DMA bus master
`timescale 1ns/100ps
module pdma_mem_model (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  slow,
  input  wire logic        mem_valid,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  output logic      [31:0] mem_rdata,
  output logic             mem_ready
);
  logic [3:0]  waited;
  logic [31:0] last;
  // Ready after the chosen wait cycles, so slow memory stretches a transfer
  assign mem_ready = mem_valid && (waited == slow);
  // Idle data toggles each cycle so a stale word never looks valid
  assign mem_rdata = (mem_ready && !mem_write) ? (mem_addr ^ 32'h5a5a_0000) : ~last;
  // Wait counter and last driven word
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waited <= 4'h0;
      last   <= 32'h0000_0000;
    end
    else
    begin
      waited <= (mem_valid && !mem_ready) ? waited + 4'h1 : 4'h0;
      last   <= mem_rdata;
    end
  end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the peripheral DMA unit
`timescale 1ns/100ps
module tb_top;
  import pdma_pkg::*;
  logic             core_clk, arst_n, cfg_cur_we, cfg_next_we;
  logic [5:0]       rx_req, rx_ack;
  logic [5:0][31:0] rx_data;
  logic [4:0]       tx_req, tx_ack;
  logic [31:0]      tx_data, cfg_ptr, mem_addr, mem_wdata, mem_rdata;
  pdma_chan_t       cfg_chan;
  logic [15:0]      cfg_cnt;
  logic [10:0]      buf_done, all_ack;
  logic             mem_valid, mem_write, mem_ready;
  logic [3:0]       slow;
  int               num_errors, checked;
  assign all_ack = {tx_ack, rx_ack};
  pdma_top u_pdma_top (.core_clk(core_clk), .arst_n(arst_n), .rx_req(rx_req),
    .rx_data(rx_data), .rx_ack(rx_ack), .tx_req(tx_req), .tx_data(tx_data), .tx_ack(tx_ack),
    .cfg_cur_we(cfg_cur_we), .cfg_next_we(cfg_next_we), .cfg_chan(cfg_chan),
    .cfg_ptr(cfg_ptr), .cfg_cnt(cfg_cnt), .buf_done(buf_done), .mem_valid(mem_valid),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready));
  pdma_mem_model u_pdma_mem_model (.core_clk(core_clk), .arst_n(arst_n), .slow(slow),
    .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready));
  task test_done;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task chk_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // Setup pulses are one cycle wide, driven on the falling edge
  task cfg(input pdma_chan_t ch, input logic nxt, input logic [31:0] p, input logic [15:0] n);
    @(negedge core_clk);
    cfg_chan = ch;
    cfg_ptr = p;
    cfg_cnt = n;
    cfg_cur_we = !nxt;
    cfg_next_we = nxt;
    @(negedge core_clk);
    cfg_cur_we = 1'b0;
    cfg_next_we = 1'b0;
  endtask
  task wait_ack(input int ch);
    logic seen;
    seen = 1'b0;
    for (int k = 0; k < 40 && !seen; k++)
    begin
      @(negedge core_clk);
      seen = (all_ack[ch] === 1'b1);
    end
    chk_flag(seen, 1'b1);
  endtask
  // Peripheral holds its request until the ack, then drops it
  task rx_word(input int i, input logic [31:0] d, input logic [31:0] a);
    rx_data[i] = d;
    rx_req[i] = 1'b1;
    wait_ack(i);
    chk_flag(buf_done[i], 1'b1);
    rx_req[i] = 1'b0;
    for (int k = 0; k < 40 && !(mem_valid && mem_write && mem_ready); k++)
      @(negedge core_clk);
    chk_word(mem_addr, a);
    chk_word(mem_wdata, d);
  endtask
  task t_tx;
    cfg(PDMA_TX_PORT0, 1'b0, 32'h0000_0100, 16'h0001);
    tx_req[1] = 1'b1;
    wait_ack(7);
    chk_word(tx_data, 32'h5a5a_0100);
    tx_req[1] = 1'b0;
    $display("test tx done");
  endtask
  task t_rx_chain;
    logic seen;
    cfg(PDMA_RX_PORT1, 1'b0, 32'h0000_0200, 16'h0001);
    cfg(PDMA_RX_PORT1, 1'b1, 32'h0000_0300, 16'h0001);
    slow = 4'h2;
    rx_word(2, 32'h1111_2222, 32'h0000_0200);
    rx_word(2, 32'h3333_4444, 32'h0000_0300);
    rx_req[2] = 1'b1;
    seen = 1'b0;
    repeat (10) @(negedge core_clk) seen |= rx_ack[2];
    chk_flag(seen, 1'b0);
    rx_req[2] = 1'b0;
    $display("test rx chain done");
  endtask
  task t_prio;
    int order[$];
    for (int k = 0; k < 11; k++) cfg(pdma_chan_t'(k), 1'b0, 32'(k * 16), 16'h0001);
    slow = 4'h0;
    rx_req = 6'h3f;
    tx_req = 5'h1f;
    for (int t = 0; t < 300 && order.size() < 11; t++)
    begin
      @(negedge core_clk);
      for (int k = 0; k < 11; k++) if (all_ack[k] === 1'b1) order.push_back(k);
      rx_req = rx_req & ~rx_ack;
      tx_req = tx_req & ~tx_ack;
    end
    chk_word(32'(order.size()), 32'd11);
    foreach (order[k]) chk_word(32'(order[k]), 32'(k));
    $display("test priority done");
  endtask
  // Clock at 40 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    num_errors++;
    test_done();
  end
  initial
  begin
    arst_n = 1'b0;
    rx_req = '0;
    rx_data = '0;
    tx_req = '0;
    cfg_cur_we = 1'b0;
    cfg_next_we = 1'b0;
    cfg_chan = PDMA_RX_DEBUG;
    cfg_ptr = '0;
    cfg_cnt = '0;
    slow = 4'h1;
    num_errors = 0;
    checked = 0;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    t_tx();
    t_rx_chain();
    t_prio();
    test_done();
  end
endmodule
